//--- rtl/cegaw_params.svh
// constants for the counter electronic gear and axis wrap block
`ifndef CEGAW_PARAMS_SVH
`define CEGAW_PARAMS_SVH

// ****************************************
// register word addresses (byte offsets)
// ****************************************
`define CEGAW_A_CTRL      8'h00
`define CEGAW_A_UNIT_SEL  8'h04
`define CEGAW_A_DIGITS    8'h08
`define CEGAW_A_ENC_GEAR  8'h0c
`define CEGAW_A_MACH_GEAR 8'h10
`define CEGAW_A_WRAP      8'h14
`define CEGAW_A_PPR       8'h18
`define CEGAW_A_TRAVEL    8'h1c
`define CEGAW_A_CNT_MIN   8'h20
`define CEGAW_A_CNT_MAX   8'h24
`define CEGAW_A_RAW_CNT   8'h28
`define CEGAW_A_RAW_LATCH 8'h2c
`define CEGAW_A_POS       8'h30
`define CEGAW_A_LATCH_POS 8'h34
`define CEGAW_A_REMAINDER 8'h38
`define CEGAW_A_STATUS    8'h3c

// ****************************************
// field positions
// ****************************************
`define CEGAW_B_ENDLESS   0
`define CEGAW_B_LSRC      1
`define CEGAW_B_BUSY      0
`define CEGAW_B_LSEEN     1

// ****************************************
// reset values and engine counts
// ****************************************
`define CEGAW_RST_GEAR    16'h0001
`define CEGAW_RST_WRAP    32'h0000_2710
`define CEGAW_RST_PPR     32'h0000_2000
`define CEGAW_RST_TRAVEL  32'h0000_1388
`define CEGAW_RST_CMIN    32'h8000_0000
`define CEGAW_RST_CMAX    32'h7fff_ffff
`define CEGAW_DIV_STEPS   7'h50
`endif

//--- rtl/cegaw_pkg.sv
// types for the counter electronic gear and axis wrap block
package cegaw_pkg;

  // software settings carried as one group
  typedef struct packed {
    logic        endless;
    logic        lsrc;
    logic [7:0]  unit_sel;
    logic [7:0]  digits;
    logic [15:0] enc_gear;
    logic [15:0] mach_gear;
    logic [31:0] wrap;
    logic [31:0] ppr;
    logic [31:0] travel;
    logic [31:0] cnt_min;
    logic [31:0] cnt_max;
  } cegaw_cfg_t;

  // conversion engine states
  typedef enum logic [3:0] {
    CV_IDLE = 4'b0001,
    CV_MUL  = 4'b0010,
    CV_DIV  = 4'b0100,
    CV_DONE = 4'b1000
  } cegaw_cv_t;

endpackage : cegaw_pkg

//--- rtl/cegaw_top.sv
// counter with electronic gear scaling and endless axis wrap
// Function
// - An axis type bit picks an endless axis that folds position or a finite one that does not.
// - On a finite axis the scaled position keeps accumulating and is never folded.
// - On an endless axis with a nonzero wrap, current and latched positions always lie in 0 to wrap minus one.
// - Scaling applies only for a nonzero unit selection; zero reports raw pulses.
// - With scaling on, counted pulses become workpiece travel in reference units.
// - The unit selection and decimal digits are stored and read back; the scaling only checks whether the unit selection is zero.
// - Travel per load revolution in reference units enters the scaling.
// - Encoder gear m and machine gear n each hold 1 to 65535; writes with zero low 16 bits are ignored.
// - A rising edge of the chosen capture source copies the count to the latched value.
// - Counting up at the maximum reloads the minimum, counting down at the minimum the maximum.
//
// Local design decisions: strobed register access and the address map.
`timescale 1ns/100ps
`include "cegaw_params.svh"

module cegaw_top
  import cegaw_pkg::*;
(
  input  wire logic        clk_i,        // 20 MHz clock
  input  wire logic        rst_n_i,      // async reset, active low
  input  wire logic        enc_a_i,      // encoder phase a pin
  input  wire logic        enc_b_i,      // encoder phase b pin
  input  wire logic        enc_z_i,      // encoder index pin
  input  wire logic        cap_di_i,     // discrete capture input pin
  input  wire logic [7:0]  addr_i,       // register byte address
  input  wire logic [31:0] wr_data_i,    // write data
  input  wire logic        wr_i,         // write strobe
  input  wire logic        rd_i,         // read strobe
  output logic      [31:0] rd_data_o,    // read data, cycle after rd_i
  output logic      [31:0] cur_pos_o,    // converted current position
  output logic      [31:0] latch_pos_o   // converted latched position
);

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [3:0] pin_s1_r;
  logic [3:0] pin_s2_r;
  logic [3:0] pin_d_r;

  // two flops, then one more stage for edges
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      {pin_s1_r, pin_s2_r, pin_d_r} <= 12'h000;
    end else begin
      pin_s1_r <= {cap_di_i, enc_z_i, enc_b_i, enc_a_i};
      pin_s2_r <= pin_s1_r;
      pin_d_r  <= pin_s2_r;
    end
  end

  // ****************************************
  // settings and status registers
  // ****************************************
  cegaw_cfg_t cfg_r, cfg_nxt;
  logic       lseen_r, lseen_nxt;
  logic       cap_evt;
  logic       busy;

  // software writes; gear zero refused
  always_comb begin
    cfg_nxt   = cfg_r;
    lseen_nxt = lseen_r | cap_evt;  // set wins over clear
    if (wr_i) begin
      unique case (addr_i)
        `CEGAW_A_CTRL: begin
          cfg_nxt.endless = wr_data_i[`CEGAW_B_ENDLESS];
          cfg_nxt.lsrc    = wr_data_i[`CEGAW_B_LSRC];
        end
        `CEGAW_A_UNIT_SEL: cfg_nxt.unit_sel = wr_data_i[7:0];
        `CEGAW_A_DIGITS:   cfg_nxt.digits   = wr_data_i[7:0];
        `CEGAW_A_ENC_GEAR: begin
          if (wr_data_i[15:0] != 16'h0000) begin
            cfg_nxt.enc_gear = wr_data_i[15:0];
          end
        end
        `CEGAW_A_MACH_GEAR: begin
          if (wr_data_i[15:0] != 16'h0000) begin
            cfg_nxt.mach_gear = wr_data_i[15:0];
          end
        end
        `CEGAW_A_WRAP:    cfg_nxt.wrap    = wr_data_i;
        `CEGAW_A_PPR:     cfg_nxt.ppr     = wr_data_i;
        `CEGAW_A_TRAVEL:  cfg_nxt.travel  = wr_data_i;
        `CEGAW_A_CNT_MIN: cfg_nxt.cnt_min = wr_data_i;
        `CEGAW_A_CNT_MAX: cfg_nxt.cnt_max = wr_data_i;
        `CEGAW_A_STATUS: begin
          if (wr_data_i[`CEGAW_B_LSEEN] && !cap_evt) begin
            lseen_nxt = 1'b0;
          end
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cfg_r <= '{endless: 1'b0, lsrc: 1'b0, unit_sel: 8'h00, digits: 8'h00,
                 enc_gear: `CEGAW_RST_GEAR, mach_gear: `CEGAW_RST_GEAR,
                 wrap: `CEGAW_RST_WRAP, ppr: `CEGAW_RST_PPR,
                 travel: `CEGAW_RST_TRAVEL, cnt_min: `CEGAW_RST_CMIN,
                 cnt_max: `CEGAW_RST_CMAX};
      lseen_r <= 1'b0;
    end else begin
      cfg_r   <= cfg_nxt;
      lseen_r <= lseen_nxt;
    end
  end

  // ****************************************
  // quadrature counter and capture
  // ****************************************
  logic [31:0] cnt_r, cnt_nxt;
  logic [31:0] cap_r, cap_nxt;
  logic        step;
  logic        up;

  // x4 decode, limit reload, capture
  always_comb begin
    step    = (pin_s2_r[0] ^ pin_d_r[0]) | (pin_s2_r[1] ^ pin_d_r[1]);
    up      = pin_s2_r[0] ^ pin_d_r[1];
    cap_evt = cfg_r.lsrc ? (pin_s2_r[3] & ~pin_d_r[3])
                         : (pin_s2_r[2] & ~pin_d_r[2]);
    cnt_nxt = cnt_r;
    if (step && up) begin
      cnt_nxt = (cnt_r == cfg_r.cnt_max) ? cfg_r.cnt_min : cnt_r + 32'h1;
    end else if (step) begin
      cnt_nxt = (cnt_r == cfg_r.cnt_min) ? cfg_r.cnt_max : cnt_r - 32'h1;
    end
    cap_nxt = cap_evt ? cnt_r : cap_r;
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      {cnt_r, cap_r} <= 64'h0;
    end else begin
      {cnt_r, cap_r} <= {cnt_nxt, cap_nxt};
    end
  end

  // ****************************************
  // conversion engine
  // ****************************************
  cegaw_cv_t   st_r, st_nxt;
  logic        sel_r, sel_nxt;      // 0 current, 1 latched
  logic        pass_r, pass_nxt;    // 0 gear divide, 1 wrap divide
  logic        neg_r, neg_nxt;
  logic [31:0] mag_r, mag_nxt;
  logic [79:0] num_r, num_nxt;
  logic [47:0] den_r, den_nxt;
  logic [47:0] rem_r, rem_nxt;
  logic [47:0] grem_r, grem_nxt;
  logic [6:0]  steps_r, steps_nxt;
  logic [31:0] pos_r, pos_nxt;
  logic [31:0] lpos_r, lpos_nxt;
  logic [31:0] src;
  logic [48:0] trial;
  logic [31:0] res;
  logic        wrap_on;

  // snapshot, scale, divide, fold, publish
  always_comb begin
    st_nxt    = st_r;
    {sel_nxt, pass_nxt, neg_nxt, mag_nxt} = {sel_r, pass_r, neg_r, mag_r};
    {num_nxt, den_nxt, rem_nxt, grem_nxt} = {num_r, den_r, rem_r, grem_r};
    {steps_nxt, pos_nxt, lpos_nxt}        = {steps_r, pos_r, lpos_r};
    src       = sel_r ? cap_r : cnt_r;
    trial     = {rem_r, num_r[79]};
    wrap_on   = cfg_r.endless && (cfg_r.wrap != 32'h0);
    res       = 32'h0;
    unique case (st_r)
      CV_IDLE: begin
        neg_nxt = src[31];
        mag_nxt = src[31] ? (32'h0 - src) : src;
        st_nxt  = CV_MUL;
      end
      CV_MUL: begin
        rem_nxt   = 48'h0;
        steps_nxt = `CEGAW_DIV_STEPS;
        if (cfg_r.unit_sel != 8'h00) begin
          num_nxt  = 80'(mag_r) * 80'(cfg_r.travel) * 80'(cfg_r.mach_gear);
          den_nxt  = 48'(cfg_r.ppr) * 48'(cfg_r.enc_gear);
          pass_nxt = 1'b0;
          st_nxt   = CV_DIV;
        end else begin
          num_nxt  = 80'(mag_r);
          grem_nxt = 48'h0;
          den_nxt  = 48'(cfg_r.wrap);
          pass_nxt = 1'b1;
          st_nxt   = wrap_on ? CV_DIV : CV_DONE;
        end
      end
      CV_DIV: begin
        if (trial >= {1'b0, den_r}) begin
          rem_nxt = 48'(trial - {1'b0, den_r});
          num_nxt = {num_r[78:0], 1'b1};
        end else begin
          rem_nxt = trial[47:0];
          num_nxt = {num_r[78:0], 1'b0};
        end
        steps_nxt = steps_r - 7'h1;
        if (steps_r == 7'h1) begin
          if (!pass_r) begin
            grem_nxt = rem_nxt;
          end
          if (!pass_r && wrap_on) begin
            pass_nxt  = 1'b1;
            den_nxt   = 48'(cfg_r.wrap);
            rem_nxt   = 48'h0;
            steps_nxt = `CEGAW_DIV_STEPS;
          end else begin
            st_nxt = CV_DONE;
          end
        end
      end
      CV_DONE: begin
        if (pass_r && wrap_on) begin
          // fold into 0 .. wrap-1 either direction
          res = (neg_r && rem_r[31:0] != 32'h0) ? cfg_r.wrap - rem_r[31:0]
                                                : rem_r[31:0];
        end else begin
          res = neg_r ? 32'h0 - num_r[31:0] : num_r[31:0];
        end
        lpos_nxt = sel_r ? res : lpos_r;
        pos_nxt  = sel_r ? pos_r : res;
        sel_nxt = ~sel_r;
        st_nxt  = CV_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_r <= CV_IDLE;
      {sel_r, pass_r, neg_r, mag_r}   <= 35'h0;
      {num_r, den_r, rem_r, grem_r}   <= 224'h0;
      {steps_r, pos_r, lpos_r}        <= 71'h0;
    end else begin
      st_r <= st_nxt;
      {sel_r, pass_r, neg_r, mag_r}   <= {sel_nxt, pass_nxt, neg_nxt, mag_nxt};
      {num_r, den_r, rem_r, grem_r}   <= {num_nxt, den_nxt, rem_nxt, grem_nxt};
      {steps_r, pos_r, lpos_r}        <= {steps_nxt, pos_nxt, lpos_nxt};
    end
  end

  assign busy        = (st_r != CV_IDLE);
  assign cur_pos_o   = pos_r;
  assign latch_pos_o = lpos_r;

  // ****************************************
  // read port
  // ****************************************
  logic [31:0] rd_r, rd_nxt;

  // data only in the cycle after rd_i
  always_comb begin
    rd_nxt = 32'h0;
    if (rd_i) begin
      unique case (addr_i)
        `CEGAW_A_CTRL:      rd_nxt = {30'h0, cfg_r.lsrc, cfg_r.endless};
        `CEGAW_A_UNIT_SEL:  rd_nxt = {24'h0, cfg_r.unit_sel};
        `CEGAW_A_DIGITS:    rd_nxt = {24'h0, cfg_r.digits};
        `CEGAW_A_ENC_GEAR:  rd_nxt = {16'h0, cfg_r.enc_gear};
        `CEGAW_A_MACH_GEAR: rd_nxt = {16'h0, cfg_r.mach_gear};
        `CEGAW_A_WRAP:      rd_nxt = cfg_r.wrap;
        `CEGAW_A_PPR:       rd_nxt = cfg_r.ppr;
        `CEGAW_A_TRAVEL:    rd_nxt = cfg_r.travel;
        `CEGAW_A_CNT_MIN:   rd_nxt = cfg_r.cnt_min;
        `CEGAW_A_CNT_MAX:   rd_nxt = cfg_r.cnt_max;
        `CEGAW_A_RAW_CNT:   rd_nxt = cnt_r;
        `CEGAW_A_RAW_LATCH: rd_nxt = cap_r;
        `CEGAW_A_POS:       rd_nxt = pos_r;
        `CEGAW_A_LATCH_POS: rd_nxt = lpos_r;
        `CEGAW_A_REMAINDER: rd_nxt = grem_r[31:0];
        `CEGAW_A_STATUS:    rd_nxt = {30'h0, lseen_r, busy};
        default:            rd_nxt = 32'h0;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rd_r <= 32'h0;
    end else begin
      rd_r <= rd_nxt;
    end
  end

  assign rd_data_o = rd_r;

endmodule : cegaw_top

//--- dv/cegaw_enc_model.sv
// quadrature encoder model for the counted axis
`timescale 1ns/100ps
module cegaw_enc_model (
  input  wire logic clk_i,   // bench clock
  input  wire logic step_i,  // one quarter step per pulse
  input  wire logic up_i,    // 1 moves forward
  input  wire logic idx_i,   // index request level
  output logic      a_o,     // phase a pin
  output logic      b_o,     // phase b pin
  output logic      z_o      // index pin
);
  logic [1:0] ph_r;  // place in the gray cycle

  // ****************************************
  // phase generation
  // ****************************************
  // a leads b moving forward, one pin changes per step
  initial ph_r = 2'h0;
  always @(posedge clk_i) begin
    if (step_i) ph_r <= up_i ? ph_r + 2'h1 : ph_r - 2'h1;
  end
  assign a_o = ph_r[1] ^ ph_r[0];
  assign b_o = ph_r[1];
  assign z_o = idx_i;
endmodule : cegaw_enc_model

//--- dv/cegaw_checker.sv
// assertion checker for the gear and wrap block
`timescale 1ns/100ps
`include "cegaw_params.svh"
module cegaw_checker
  import cegaw_pkg::*;
(
  input wire logic        clk_i,       // clock
  input wire logic        rst_n_i,     // reset, active low
  input wire logic [7:0]  addr_i,      // address
  input wire logic [31:0] wr_data_i,   // write data
  input wire logic        wr_i,        // write strobe
  input wire logic        rd_i,        // read strobe
  input wire logic [31:0] rd_data_o,   // read data
  input wire logic [31:0] cur_pos_o,   // current position
  input wire logic [31:0] latch_pos_o  // latched position
);
  logic [1:0]  ctrl_r;   // axis type and capture source
  logic [7:0]  unit_r;   // unit selection
  logic [7:0]  dig_r;    // decimal digits
  logic [15:0] m_r;      // encoder gear
  logic [15:0] n_r;      // machine gear
  logic [31:0] wrap_r;   // wrap position
  logic [9:0]  quiet_r;  // cycles since the last write
  logic        settled;  // endless setup has had time to land

  // ****************************************
  // shadow of the settings
  // ****************************************
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl_r  <= 2'h0;
      unit_r  <= 8'h0;
      dig_r   <= 8'h0;
      m_r     <= 16'h1;
      n_r     <= 16'h1;
      wrap_r  <= 32'h2710;
      quiet_r <= 10'h0;
    end else begin
      quiet_r <= wr_i ? 10'h0 : (quiet_r == 10'h3ff ? quiet_r : quiet_r + 10'h1);
      if (wr_i && addr_i == `CEGAW_A_CTRL) ctrl_r <= wr_data_i[1:0];
      if (wr_i && addr_i == `CEGAW_A_UNIT_SEL) unit_r <= wr_data_i[7:0];
      if (wr_i && addr_i == `CEGAW_A_DIGITS) dig_r <= wr_data_i[7:0];
      if (wr_i && addr_i == `CEGAW_A_ENC_GEAR && wr_data_i[15:0] != 16'h0) m_r <= wr_data_i[15:0];
      if (wr_i && addr_i == `CEGAW_A_MACH_GEAR && wr_data_i[15:0] != 16'h0) n_r <= wr_data_i[15:0];
      if (wr_i && addr_i == `CEGAW_A_WRAP) wrap_r <= wr_data_i;
    end
  end
  assign settled = quiet_r == 10'h3ff && ctrl_r[0] && wrap_r != 32'h0;

  // ****************************************
  // properties
  // ****************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  property p_rd_quiet; !rd_i |=> rd_data_o == 32'h0; endproperty
  property p_ctrl_rd; rd_i && addr_i == `CEGAW_A_CTRL |=> rd_data_o == {30'h0, ctrl_r}; endproperty
  property p_unit_rd; rd_i && addr_i == `CEGAW_A_UNIT_SEL |=> rd_data_o == {24'h0, unit_r};
  endproperty
  property p_dig_rd; rd_i && addr_i == `CEGAW_A_DIGITS |=> rd_data_o == {24'h0, dig_r}; endproperty
  property p_m_rd; rd_i && addr_i == `CEGAW_A_ENC_GEAR |=> rd_data_o == {16'h0, m_r}; endproperty
  property p_n_rd; rd_i && addr_i == `CEGAW_A_MACH_GEAR |=> rd_data_o == {16'h0, n_r}; endproperty
  property p_wrap_rd; rd_i && addr_i == `CEGAW_A_WRAP |=> rd_data_o == wrap_r; endproperty
  property p_unmapped; rd_i && addr_i > `CEGAW_A_STATUS |=> rd_data_o == 32'h0; endproperty
  property p_cur_range; settled |-> cur_pos_o < wrap_r; endproperty
  property p_lat_range; settled |-> latch_pos_o < wrap_r; endproperty
  a_rd_quiet: assert property (p_rd_quiet) else $error("read data outside its slot");
  a_ctrl_rd: assert property (p_ctrl_rd) else $error("axis control readback wrong");
  a_unit_rd: assert property (p_unit_rd) else $error("unit readback wrong");
  a_dig_rd: assert property (p_dig_rd) else $error("digits readback wrong");
  a_m_rd: assert property (p_m_rd) else $error("encoder gear readback wrong");
  a_n_rd: assert property (p_n_rd) else $error("machine gear readback wrong");
  a_wrap_rd: assert property (p_wrap_rd) else $error("wrap readback wrong");
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  a_cur_range: assert property (p_cur_range) else $error("position out of wrap range");
  a_lat_range: assert property (p_lat_range) else $error("latch out of wrap range");
  c_endless: cover property (settled);
  c_unmapped: cover property (rd_i && addr_i > `CEGAW_A_STATUS);
  c_gear_zero: cover property (wr_i && addr_i == `CEGAW_A_ENC_GEAR && wr_data_i == 32'h0);
endmodule : cegaw_checker

//--- dv/tb.sv
// self-checking bench for the gear and wrap block
`timescale 1ns/100ps
module tb;
  import cegaw_pkg::*;
  logic        clk_i, rst_n_i, cap_di_i, wr_i, rd_i, step, up, idx, enc_a, enc_b, enc_z;
  logic [7:0]  addr_i;
  logic [31:0] wr_data_i, rd_data_o, cur_pos_o, latch_pos_o, seed, d;
  int          n_fail, checked, cnt, lcnt, cmin, cmax, trav, ppr, wrap, m, n, unit, endl, k;
  logic [7:0]  ra [12] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h20,
                           8'h24, 8'h40, 8'h3a};
  logic [31:0] rv [12] = '{32'h0, 32'h0, 32'h0, 32'h1, 32'h1, 32'h2710, 32'h2000, 32'h1388,
                           32'h8000_0000, 32'h7fff_ffff, 32'h0, 32'h0};

  cegaw_top dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .enc_a_i(enc_a), .enc_b_i(enc_b),
    .enc_z_i(enc_z), .cap_di_i(cap_di_i), .addr_i(addr_i), .wr_data_i(wr_data_i), .wr_i(wr_i),
    .rd_i(rd_i), .rd_data_o(rd_data_o), .cur_pos_o(cur_pos_o), .latch_pos_o(latch_pos_o));
  cegaw_enc_model u_enc (.clk_i(clk_i), .step_i(step), .up_i(up), .idx_i(idx), .a_o(enc_a),
    .b_o(enc_b), .z_o(enc_z));

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  // expected converted position of a raw count
  function automatic logic [31:0] conv(input int c);
    longint v;
    v = (c < 0) ? -longint'(c) : longint'(c);
    v = (unit == 0) ? c : ((c < 0) ? -(v * trav * n / (ppr * m)) : v * trav * n / (ppr * m));
    if (endl != 0 && wrap != 0) v = ((v % wrap) + wrap) % wrap;
    return v[31:0];
  endfunction : conv
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    addr_i <= a; wr_data_i <= v; wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
    @(posedge clk_i);
  endtask : wr
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    addr_i <= a; rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 v = rd_data_o;
    @(posedge clk_i);
  endtask : rd
  // quarter steps, five clocks apart, counter limits honoured
  task automatic mv(input int steps, input bit dir);
    repeat (steps) begin
      step <= 1'b1; up <= dir;
      @(posedge clk_i);
      step <= 1'b0;
      repeat (4) @(posedge clk_i);
      if (dir) cnt = (cnt == cmax) ? cmin : cnt + 1;
      else cnt = (cnt == cmin) ? cmax : cnt - 1;
    end
  endtask : mv
  task automatic pulse(input bit di);
    if (di) cap_di_i <= 1'b1; else idx <= 1'b1;
    repeat (4) @(posedge clk_i);
    cap_di_i <= 1'b0; idx <= 1'b0;
    repeat (600) @(posedge clk_i);
  endtask : pulse
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : wrap_up

  // ****************************************
  // clock, watchdog, main sequence
  // ****************************************
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  initial begin
    repeat (100000) @(posedge clk_i);
    n_fail++;
    wrap_up;
  end
  initial begin
    rst_n_i = 1'b0; cap_di_i = 1'b0; wr_i = 1'b0; rd_i = 1'b0; step = 1'b0; up = 1'b0;
    idx = 1'b0; addr_i = 8'h0; wr_data_i = 32'h0; seed = 32'h13e69;
    cnt = 0; cmin = 32'h8000_0000; cmax = 32'h7fff_ffff; unit = 0; endl = 0; m = 1; n = 1;
    repeat (3) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(posedge clk_i);
    for (k = 0; k < 12; k++) begin
      rd(ra[k], d);
      chk(d, rv[k]);
    end
    wr(8'h0c, 32'h0);
    rd(8'h0c, d);
    chk(d, 32'h1);
    wr(8'h0c, 32'hffff);
    rd(8'h0c, d);
    chk(d, 32'hffff);
    $display("test registers done");
    mv(5 + xs() % 30, 1'b1);
    repeat (600) @(posedge clk_i);
    chk(cur_pos_o, cnt);
    $display("test raw done");
    unit = 1; ppr = 100; trav = 1 + xs() % 5000; m = 1 + xs() % 7; n = 1 + xs() % 7;
    wr(8'h04, 32'h1);
    wr(8'h08, 32'h3);
    wr(8'h18, ppr);
    wr(8'h1c, trav);
    wr(8'h0c, m);
    wr(8'h10, n);
    for (k = 0; k < 3; k++) begin
      mv((k == 1) ? 400 + xs() % 100 : 250, k != 1);
      repeat (600) @(posedge clk_i);
      chk(cur_pos_o, conv(cnt));
    end
    $display("test scaling done");
    lcnt = cnt;
    pulse(1'b0);
    chk(latch_pos_o, conv(lcnt));
    wr(8'h00, 32'h2);
    mv(7, 1'b1);
    pulse(1'b0);
    chk(latch_pos_o, conv(lcnt));
    lcnt = cnt;
    pulse(1'b1);
    chk(latch_pos_o, conv(lcnt));
    $display("test capture done");
    wrap = 50 + xs() % 300; endl = 1;
    wr(8'h14, wrap);
    wr(8'h00, 32'h3);
    mv(300, 1'b0);
    repeat (600) @(posedge clk_i);
    chk(cur_pos_o, conv(cnt));
    chk(latch_pos_o, conv(lcnt));
    $display("test endless done");
    cmax = cnt + 3; cmin = cnt - 2;
    wr(8'h24, cmax);
    wr(8'h20, cmin);
    mv(5, 1'b1);
    rd(8'h28, d);
    chk(d, cnt);
    mv(3, 1'b0);
    rd(8'h28, d);
    chk(d, cnt);
    $display("test limits done");
    wrap_up;
  end
endmodule : tb

bind cegaw_top cegaw_checker u_chk (.clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
  .wr_data_i(wr_data_i), .wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rd_data_o),
  .cur_pos_o(cur_pos_o), .latch_pos_o(latch_pos_o));
